// ---- rtl/sigwin_map.vh ----
// Constants for the signature analyzer window block
`ifndef SIGWIN_MAP_VH
`define SIGWIN_MAP_VH
`define SIGWIN_WIDTH 16
`define SIGWIN_RESET_SIG 16'h0000
`define SIGWIN_TAP_A 15
`define SIGWIN_TAP_B 11
`define SIGWIN_TAP_C 8
`define SIGWIN_TAP_D 6
`define SIGWIN_CHAR_W 8
`define SIGWIN_NIB_W 4
`define SIGWIN_CHAR_ZERO 8'h30
`endif

// ---- rtl/sigwin_hexchar.v ----
// Nibble to display character lookup, registered output
`timescale 1ns/10ps
module sigwin_hexchar (
	input wire clk,
	input wire nrst,
	input wire [3:0] nibble,
	output reg [7:0] char_reg
);
`include "sigwin_map.vh"
reg [7:0] char_next;

// Character set 0-9 A C F H P U
always @* begin
	case (nibble)
	4'h0: char_next = 8'h30;
	4'h1: char_next = 8'h31;
	4'h2: char_next = 8'h32;
	4'h3: char_next = 8'h33;
	4'h4: char_next = 8'h34;
	4'h5: char_next = 8'h35;
	4'h6: char_next = 8'h36;
	4'h7: char_next = 8'h37;
	4'h8: char_next = 8'h38;
	4'h9: char_next = 8'h39;
	4'ha: char_next = 8'h41;
	4'hb: char_next = 8'h43;
	4'hc: char_next = 8'h46;
	4'hd: char_next = 8'h48;
	4'he: char_next = 8'h50;
	default: char_next = 8'h55;
	endcase
end

always @(posedge clk) begin
	if (!nrst) begin
		char_reg <= `SIGWIN_CHAR_ZERO;
	end else begin
		char_reg <= char_next;
	end
end
endmodule // sigwin_hexchar

// ---- rtl/sigwin_top.v ----
// Signature analyzer with start/stop measurement window
`timescale 1ns/10ps
module sigwin_top (
	input wire MCLK,
	input wire NRST,
	input wire PROBE_CLK,
	input wire PROBE_DATA,
	input wire START_IN,
	input wire STOP_IN,
	input wire CLK_FALL_SEL,
	input wire START_LOW_SEL,
	input wire STOP_LOW_SEL,
	output reg [15:0] SIG_VALUE,
	output reg SIG_VALID,
	output reg WINDOW_OPEN,
	output wire [7:0] SIG_CHAR3,
	output wire [7:0] SIG_CHAR2,
	output wire [7:0] SIG_CHAR1,
	output wire [7:0] SIG_CHAR0
);
`include "sigwin_map.vh"

////////////////////////////////////////////////////////////////////////
// Synchronisers, one per pin
reg [2:0] clk_sync_reg;
reg [1:0] data_sync_reg;
reg [1:0] start_sync_reg;
reg [1:0] stop_sync_reg;
reg [1:0] fall_sel_sync_reg;
reg [1:0] start_low_sync_reg;
reg [1:0] stop_low_sync_reg;
reg [2:0] arm_reg;

always @(posedge MCLK) begin
	if (!NRST) begin
		clk_sync_reg <= 3'h0;
	end else begin
		clk_sync_reg <= {clk_sync_reg[1:0], PROBE_CLK};
	end
end

always @(posedge MCLK) begin
	if (!NRST) begin
		data_sync_reg <= 2'h0;
	end else begin
		data_sync_reg <= {data_sync_reg[0], PROBE_DATA};
	end
end

always @(posedge MCLK) begin
	if (!NRST) begin
		start_sync_reg <= 2'h0;
	end else begin
		start_sync_reg <= {start_sync_reg[0], START_IN};
	end
end

always @(posedge MCLK) begin
	if (!NRST) begin
		stop_sync_reg <= 2'h0;
	end else begin
		stop_sync_reg <= {stop_sync_reg[0], STOP_IN};
	end
end

always @(posedge MCLK) begin
	if (!NRST) begin
		fall_sel_sync_reg <= 2'h0;
	end else begin
		fall_sel_sync_reg <= {fall_sel_sync_reg[0], CLK_FALL_SEL};
	end
end

always @(posedge MCLK) begin
	if (!NRST) begin
		start_low_sync_reg <= 2'h0;
	end else begin
		start_low_sync_reg <= {start_low_sync_reg[0], START_LOW_SEL};
	end
end

always @(posedge MCLK) begin
	if (!NRST) begin
		stop_low_sync_reg <= 2'h0;
	end else begin
		stop_low_sync_reg <= {stop_low_sync_reg[0], STOP_LOW_SEL};
	end
end

// Blocks false edges until the clock syncs hold pin values
always @(posedge MCLK) begin
	if (!NRST) begin
		arm_reg <= 3'h0;
	end else begin
		arm_reg <= {arm_reg[1:0], 1'b1};
	end
end

////////////////////////////////////////////////////////////////////////
// Edge qualification
wire clk_now = clk_sync_reg[1];
wire clk_prev = clk_sync_reg[2];
wire rise = clk_now & ~clk_prev;
wire fall = ~clk_now & clk_prev;
wire fall_sel = fall_sel_sync_reg[1];
wire start_low = start_low_sync_reg[1];
wire stop_low = stop_low_sync_reg[1];
wire probe_bit = data_sync_reg[1];
// Self-test setup: CLK_FALL_SEL high gives negative edges
wire qual_edge = arm_reg[2] & (fall_sel ? fall : rise);
wire start_act = start_sync_reg[1] ^ start_low;
wire stop_act = stop_sync_reg[1] ^ stop_low;

////////////////////////////////////////////////////////////////////////
// Feedback function
function [15:0] sigwin_shift;
	input [15:0] cur;
	input din;
	reg fb;
	begin
		fb = cur[`SIGWIN_TAP_A] ^ cur[`SIGWIN_TAP_B] ^
			cur[`SIGWIN_TAP_C] ^ cur[`SIGWIN_TAP_D];
		sigwin_shift = {cur[14:0], din ^ fb};
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Window control and shift register
localparam ST_IDLE = 2'h0;
localparam ST_OPEN = 2'h1;

reg [1:0] state_reg;
reg [1:0] state_next;
reg [15:0] shreg_reg;
reg [15:0] shreg_next;
reg valid_next;
reg [15:0] sig_next;

always @* begin
	state_next = state_reg;
	shreg_next = shreg_reg;
	valid_next = SIG_VALID;
	sig_next = SIG_VALUE;
	case (state_reg)
	ST_IDLE: begin
		if (qual_edge && start_act) begin
			// Opening edge samples the first bit
			state_next = ST_OPEN;
			shreg_next = sigwin_shift(`SIGWIN_RESET_SIG,
				probe_bit);
			valid_next = 1'b0;
		end
	end
	ST_OPEN: begin
		if (qual_edge) begin
			if (stop_act) begin
				state_next = ST_IDLE;
				sig_next = shreg_reg;
				valid_next = 1'b1;
			end else begin
				shreg_next = sigwin_shift(shreg_reg,
					probe_bit);
			end
		end
	end
	default: state_next = ST_IDLE;
	endcase
end

always @(posedge MCLK) begin
	if (!NRST) begin
		state_reg <= ST_IDLE;
		shreg_reg <= `SIGWIN_RESET_SIG;
	end else begin
		state_reg <= state_next;
		shreg_reg <= shreg_next;
	end
end

// Outputs straight from registers
always @(posedge MCLK) begin
	if (!NRST) begin
		SIG_VALUE <= `SIGWIN_RESET_SIG;
		SIG_VALID <= 1'b0;
		WINDOW_OPEN <= 1'b0;
	end else begin
		SIG_VALUE <= sig_next;
		SIG_VALID <= valid_next;
		WINDOW_OPEN <= (state_next == ST_OPEN);
	end
end

////////////////////////////////////////////////////////////////////////
// Display characters
genvar gi;
wire [31:0] chars;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_chr
		sigwin_hexchar u_chr (
			.clk(MCLK),
			.nrst(NRST),
			.nibble(SIG_VALUE[gi*4+3:gi*4]),
			.char_reg(chars[gi*8+7:gi*8])
		);
	end
endgenerate
assign SIG_CHAR0 = chars[7:0];
assign SIG_CHAR1 = chars[15:8];
assign SIG_CHAR2 = chars[23:16];
assign SIG_CHAR3 = chars[31:24];
endmodule // sigwin_top

// ---- tb/sigwin_chk.sv ----
// Port checker for the signature window block
`timescale 1ns/10ps
module sigwin_chk(input wire MCLK, NRST, START_IN, STOP_IN,
	START_LOW_SEL, STOP_LOW_SEL, SIG_VALID, WINDOW_OPEN,
	input wire [15:0] SIG_VALUE, input wire [7:0] SIG_CHAR3, SIG_CHAR0);
default clocking @(posedge MCLK); endclocking
default disable iff (!NRST);
AST_OPEN_CLR: assert property ($rose(WINDOW_OPEN) |-> !SIG_VALID)
	else $error("valid kept at open");
AST_OPEN_START: assert property ($rose(WINDOW_OPEN) |->
	$past(START_IN ^ START_LOW_SEL, 3)) else $error("open w/o start");
AST_CLOSE_STOP: assert property ($fell(WINDOW_OPEN) |->
	$past(STOP_IN ^ STOP_LOW_SEL, 3)) else $error("close w/o stop");
AST_CLOSE_VALID: assert property ($fell(WINDOW_OPEN) |->
	##[0:1] SIG_VALID) else $error("no valid at close");
AST_SIG_HOLD: assert property (!$stable(SIG_VALUE) |->
	!WINDOW_OPEN && SIG_VALID) else $error("value moved");
AST_VALID_DROP: assert property ($fell(SIG_VALID) |-> WINDOW_OPEN)
	else $error("valid dropped");
AST_CHAR_DIGIT: assert property ($stable(SIG_VALUE) &&
	SIG_VALUE[3:0] < 4'hA |-> SIG_CHAR0 == 8'h30 + SIG_VALUE[3:0])
	else $error("bad digit");
AST_CHAR_KIND: assert property ($stable(SIG_VALUE) |->
	(SIG_CHAR3 > 8'h40) == (SIG_VALUE[15:12] > 4'h9)) else $error("bad char");
COV_OPEN: cover property ($rose(WINDOW_OPEN));
COV_CLOSE: cover property ($fell(WINDOW_OPEN));
COV_LETTER: cover property (SIG_CHAR3 > 8'h40);
endmodule // sigwin_chk
bind sigwin_top sigwin_chk u_sigwin_chk(.*);

// ---- tb/sigwin_cut.sv ----
// Circuit under test model driving clock, data, start and stop
`timescale 1ns/10ps
module sigwin_cut(output reg clk_o = 0, dat_o = 0, sta_o = 0, sto_o = 0);
	task edge1(input f, d, s, p);
		begin
			dat_o = d;
			sta_o = s;
			sto_o = p;
			#100 clk_o = !f;
			#100 clk_o = f;
		end
	endtask
	task frame(input f, sl, pl, input [31:0] b, input integer n);
		integer i;
		begin
			clk_o = f;
			sta_o = sl;
			sto_o = pl;
			#400 edge1(f, !dat_o, sl, !pl);
			for (i = 0; i < n; i++) edge1(f, b[i], sl ^ (i < 2), pl);
			edge1(f, !dat_o, sl, !pl);
			sto_o = pl;
			dat_o = !dat_o;
		end
	endtask
endmodule // sigwin_cut

// ---- tb/sigwin_top_tb_top.sv ----
// Self-checking bench for the signature window block
`timescale 1ns/10ps
module sigwin_top_tb_top;
	reg MCLK = 0, NRST = 0, CLK_FALL_SEL = 0, START_LOW_SEL = 0;
	reg STOP_LOW_SEL = 0;
	wire PROBE_CLK, PROBE_DATA, START_IN, STOP_IN, SIG_VALID, WINDOW_OPEN;
	wire [15:0] SIG_VALUE;
	wire [7:0] SIG_CHAR3, SIG_CHAR2, SIG_CHAR1, SIG_CHAR0;
	integer n_errors = 0, n_compared = 0;
	sigwin_top u_sigwin_top(.*);
	sigwin_cut u_sigwin_cut(.clk_o(PROBE_CLK), .dat_o(PROBE_DATA),
		.sta_o(START_IN), .sto_o(STOP_IN));
	initial forever #12.5 MCLK = !MCLK;
	task chk(input [31:0] got, exp);
		begin
			n_compared++;
			if (got !== exp) begin
				n_errors++;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	function [7:0] ch(input [3:0] v);
		ch = v < 10 ? 8'h30 + v : "ACFHPU" >> 8 * (15 - v);
	endfunction
	task run(input f, sl, pl, input [31:0] b, input integer n);
		reg [15:0] s;
		integer i;
		begin
			@(negedge MCLK);
			{CLK_FALL_SEL, START_LOW_SEL, STOP_LOW_SEL} = {f, sl, pl};
			u_sigwin_cut.frame(f, sl, pl, b, n);
			s = 16'h0000;
			for (i = 0; i < n; i++) s = {s[14:0], ^(s & 16'h8940) ^ b[i]};
			repeat (6) @(negedge MCLK);
			chk({WINDOW_OPEN, SIG_VALID, SIG_VALUE}, {2'b01, s});
			chk({SIG_CHAR3, SIG_CHAR2, SIG_CHAR1, SIG_CHAR0},
				{ch(s[15:12]), ch(s[11:8]), ch(s[7:4]), ch(s[3:0])});
		end
	endtask
	task t_rise; run(0, 0, 0, 32'hB3A5_0F1C, 24); endtask
	task t_self; run(1, 1, 1, 32'h6D21_97E4, 32); endtask
	task t_mix; run(0, 1, 0, 32'h0000_0001, 1); endtask
	task t_rst;
		begin
			@(negedge MCLK);
			{CLK_FALL_SEL, START_LOW_SEL, STOP_LOW_SEL} = 3'b101;
			fork
				u_sigwin_cut.frame(1, 0, 1, 32'h0000_03C5, 10);
				begin
					repeat (40) @(negedge MCLK);
					NRST = 0;
					repeat (4) @(negedge MCLK);
					NRST = 1;
				end
			join
			repeat (6) @(negedge MCLK);
			chk({WINDOW_OPEN, SIG_VALID, SIG_VALUE}, 32'h0000_0000);
			chk({SIG_CHAR3, SIG_CHAR2, SIG_CHAR1, SIG_CHAR0}, 32'h3030_3030);
			run(1, 0, 1, 32'h0000_03C5, 10);
		end
	endtask
	task report_and_stop;
		begin
			$display("errors %0d compared %0d", n_errors, n_compared);
			if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (20) @(negedge MCLK);
		NRST = 1;
		repeat (4) @(negedge MCLK);
		t_rise;
		t_self;
		t_mix;
		t_rst;
		report_and_stop;
	end
endmodule // sigwin_top_tb_top
